// ===== rtl/rap_alarm_pwc.sv
`timescale 1ns/1ps

// Contract
// - alarm matching only while enable bit set
// - mask bits 13:10 choose compared digits
// - mask codes half-second through year
// - yearly alarm on February 29 not annual
// - repeat count decrements after each alarm
// - count zero without endless_repeat_bit: single alarm
// - at zero without endless_repeat_bit: last alarm, enable cleared
// - count FFh gives up to 255 repeats
// - endless_repeat_bit set: count wraps 00h to FFh
// - interrupt request on every alarm
// - pulse output toggles at each alarm
// - autonomous power up, settle, sample, down
// - pin driven only when all enables set
// - polarity bit selects active level
// - enabled brown-out resets unit, clears enable
// - stability window delays sampling, zero none
// - sample window length, all-ones always on
module rap_alarm_pwc (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire rap_pkg::rap_bus_type BUS_REQ,
    output logic [15:0] RD_DATA,
    input wire rap_pkg::rap_time_type CUR_TIME,
    input wire logic TICK_HALF,
    input wire logic PWC_TICK,
    input wire logic ROLLOVER_SYNC,
    input wire logic BROWNOUT_EN,
    input wire logic BROWNOUT_PIN,
    output logic CLK_UNIT_EN,
    output logic ALARM_IRQ,
    output logic ALARM_PULSE,
    output logic PWR_SWITCH_O,
    output logic PWR_SWITCH_OE,
    output logic SAMPLE_WINDOW
);
    import rap_pkg::*;

    typedef struct packed {
        logic [15:0] alcfg;
        logic [15:0] al_minsec;
        logic [15:0] al_wdhr;
        logic [15:0] al_mthdy;
        logic [15:0] pwctl;
        logic [15:0] swt;
        logic [15:0] ctrl;
        logic [2:0] bo_sync;
        logic bo_level;
        logic bo_seen;
        rap_pwc_type fsm;
        logic [7:0] cnt;
        logic pwr_on;
        logic irq;
        logic pulse;
        logic pin_o;
        logic pin_oe;
        logic samp_act;
        logic [15:0] rdata;
    } rap_state_type;

    rap_state_type s;
    rap_state_type next_s;
    logic match;
    logic fire;
    logic wr_cfg;

    // ************************************************************
    // alarm compare
    // ************************************************************
    // a Feb 29 yearly alarm matches only when the date really is Feb 29
    function automatic logic alarm_match(input logic [3:0] m, input rap_time_type c,
                                         input rap_time_type a);
        logic s1;
        logic s10;
        logic m1;
        logic m10;
        logic hr;
        logic wd;
        logic dy;
        logic mo;
        logic r;
        s1 = !c.half && (c.sec_one == a.sec_one);
        s10 = s1 && (c.sec_ten == a.sec_ten);
        m1 = s10 && (c.min_one == a.min_one);
        m10 = m1 && (c.min_ten == a.min_ten);
        hr = m10 && (c.hr_one == a.hr_one) && (c.hr_ten == a.hr_ten);
        wd = hr && (c.wday == a.wday);
        dy = hr && (c.day_one == a.day_one) && (c.day_ten == a.day_ten);
        mo = dy && (c.mon_one == a.mon_one) && (c.mon_ten == a.mon_ten);
        case (m)
            MASK_HALF: r = 1'h1;
            MASK_SEC: r = !c.half;
            MASK_TENSEC: r = s1;
            MASK_MIN: r = s10;
            MASK_TENMIN: r = m1;
            MASK_HOUR: r = m10;
            MASK_DAY: r = hr;
            MASK_WEEK: r = wd;
            MASK_MONTH: r = dy;
            MASK_YEAR: r = mo;
            default: r = 1'h0;
        endcase
        return r;
    endfunction

    function automatic rap_time_type alarm_value(input logic [15:0] ms, input logic [15:0] wh,
                                                 input logic [15:0] md);
        rap_time_type t;
        t = '0;
        t.min_ten = ms[14:12];
        t.min_one = ms[11:8];
        t.sec_ten = ms[6:4];
        t.sec_one = ms[3:0];
        t.wday = wh[10:8];
        t.hr_ten = wh[5:4];
        t.hr_one = wh[3:0];
        t.mon_ten = md[12];
        t.mon_one = md[11:8];
        t.day_ten = md[5:4];
        t.day_one = md[3:0];
        return t;
    endfunction

    assign match = alarm_match(s.alcfg[ALCFG_MASK_HI:ALCFG_MASK_LO], CUR_TIME,
                               alarm_value(s.al_minsec, s.al_wdhr, s.al_mthdy));
    assign fire = TICK_HALF && s.alcfg[ALCFG_EN_BIT] && s.ctrl[CTRL_CU_EN_BIT]
                  && match;
    assign wr_cfg = BUS_REQ.wr && (BUS_REQ.addr == ADDR_ALCFG);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.irq = 1'h0;
        next_s.rdata = REG_RESET;
        next_s.bo_sync = {s.bo_sync[1:0], BROWNOUT_PIN};
        if (s.bo_sync[2] == s.bo_sync[1]) begin
            next_s.bo_level = s.bo_sync[2];
        end

        // alarm issue; a same-cycle software write to the config wins below
        if (fire) begin
            next_s.irq = 1'h1;
            next_s.pulse = !s.pulse;
            if (s.alcfg[ALCFG_RPT_HI:0] != CNT_ZERO) begin
                next_s.alcfg[ALCFG_RPT_HI:0] = s.alcfg[ALCFG_RPT_HI:0] - CNT_ONE;
            end else if (s.alcfg[ALCFG_ENDLESS_REPEAT_BIT_BIT]) begin
                next_s.alcfg[ALCFG_RPT_HI:0] = CNT_ALL;
            end else begin
                next_s.alcfg[ALCFG_EN_BIT] = 1'h0;
            end
        end

        // power control sequence, started by an alarm and stepped by the power-control tick
        case (s.fsm)
            PWC_IDLE: begin
                if (fire && s.pwctl[PWCTL_EN_BIT]) begin
                    if (s.swt[SWT_STAB_HI:SWT_STAB_LO] != CNT_ZERO) begin
                        next_s.fsm = PWC_STAB;
                        next_s.cnt = s.swt[SWT_STAB_HI:SWT_STAB_LO];
                        next_s.pwr_on = 1'h1;
                    end else if (s.swt[SWT_SAMP_HI:0] != CNT_ZERO) begin
                        next_s.fsm = PWC_SAMP;
                        next_s.cnt = s.swt[SWT_SAMP_HI:0];
                        next_s.pwr_on = 1'h1;
                    end
                end
            end
            PWC_STAB: begin
                if (PWC_TICK) begin
                    if (s.cnt == CNT_ONE) begin
                        if (s.swt[SWT_SAMP_HI:0] != CNT_ZERO) begin
                            next_s.fsm = PWC_SAMP;
                            next_s.cnt = s.swt[SWT_SAMP_HI:0];
                        end else begin
                            next_s.fsm = PWC_IDLE;
                            next_s.pwr_on = 1'h0;
                        end
                    end else begin
                        next_s.cnt = s.cnt - CNT_ONE;
                    end
                end
            end
            PWC_SAMP: begin
                // an all-ones sample count never runs out
                if (PWC_TICK && (s.swt[SWT_SAMP_HI:0] != CNT_ALL)) begin
                    if (s.cnt == CNT_ONE) begin
                        next_s.fsm = PWC_IDLE;
                        next_s.pwr_on = 1'h0;
                    end else begin
                        next_s.cnt = s.cnt - CNT_ONE;
                    end
                end
            end
            default: begin
                next_s.fsm = PWC_IDLE;
                next_s.pwr_on = 1'h0;
            end
        endcase
        if (!s.pwctl[PWCTL_EN_BIT] || !s.ctrl[CTRL_CU_EN_BIT]) begin
            next_s.fsm = PWC_IDLE;
            next_s.pwr_on = 1'h0;
        end

        // ************************************************************
        // register port
        // ************************************************************
        if (BUS_REQ.wr) begin
            if (BUS_REQ.addr == ADDR_ALCFG) begin
                next_s.alcfg = BUS_REQ.wdata;
            end else if (BUS_REQ.addr == ADDR_AL_MINSEC) begin
                next_s.al_minsec = BUS_REQ.wdata & 16'h7f7f;
            end else if (BUS_REQ.addr == ADDR_AL_WDHR) begin
                next_s.al_wdhr = BUS_REQ.wdata & 16'h073f;
            end else if (BUS_REQ.addr == ADDR_AL_MTHDY) begin
                next_s.al_mthdy = BUS_REQ.wdata & 16'h1f3f;
            end else if (BUS_REQ.addr == ADDR_PWCTL) begin
                next_s.pwctl = BUS_REQ.wdata & 16'hc000;
            end else if (BUS_REQ.addr == ADDR_SWT) begin
                next_s.swt = BUS_REQ.wdata;
            end else if (BUS_REQ.addr == ADDR_CTRL) begin
                next_s.ctrl = BUS_REQ.wdata & 16'h000f;
            end else if (BUS_REQ.addr == ADDR_STATUS) begin
                if (BUS_REQ.wdata[STAT_BO_SEEN_BIT]) begin
                    next_s.bo_seen = 1'h0;
                end
            end
        end
        if (BUS_REQ.rd) begin
            if (BUS_REQ.addr == ADDR_ALCFG) begin
                next_s.rdata = s.alcfg;
            end else if (BUS_REQ.addr == ADDR_AL_MINSEC) begin
                next_s.rdata = s.al_minsec;
            end else if (BUS_REQ.addr == ADDR_AL_WDHR) begin
                next_s.rdata = s.al_wdhr;
            end else if (BUS_REQ.addr == ADDR_AL_MTHDY) begin
                next_s.rdata = s.al_mthdy;
            end else if (BUS_REQ.addr == ADDR_PWCTL) begin
                next_s.rdata = s.pwctl;
            end else if (BUS_REQ.addr == ADDR_SWT) begin
                next_s.rdata = s.swt;
            end else if (BUS_REQ.addr == ADDR_CTRL) begin
                next_s.rdata = s.ctrl;
            end else if (BUS_REQ.addr == ADDR_STATUS) begin
                next_s.rdata = {10'h000, s.fsm, s.bo_seen, s.samp_act, s.pwr_on,
                                ROLLOVER_SYNC};
            end
        end

        // brown-out last so it beats any write; sticky flag set wins over clear
        if (BROWNOUT_EN && s.bo_level) begin
            next_s.ctrl[CTRL_CU_EN_BIT] = 1'h0;
            next_s.alcfg[ALCFG_EN_BIT] = 1'h0;
            next_s.fsm = PWC_IDLE;
            next_s.pwr_on = 1'h0;
            next_s.bo_seen = 1'h1;
        end

        // pin drive from the settled next values, so outputs stay registered
        next_s.pin_oe = next_s.ctrl[CTRL_CU_EN_BIT] && next_s.pwctl[PWCTL_EN_BIT]
                        && next_s.ctrl[CTRL_PIN_OE_BIT]
                        && (next_s.ctrl[CTRL_PIN_SEL_HI:CTRL_PIN_SEL_LO] == PIN_SEL_PWC);
        next_s.pin_o = next_s.pin_oe && (next_s.pwctl[PWCTL_POL_BIT] ? next_s.pwr_on
                                                                      : !next_s.pwr_on);
        next_s.samp_act = (next_s.fsm == PWC_SAMP)
                          || (next_s.swt[SWT_SAMP_HI:0] == CNT_ALL);
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign RD_DATA = s.rdata;
    assign CLK_UNIT_EN = s.ctrl[CTRL_CU_EN_BIT];
    assign ALARM_IRQ = s.irq;
    assign ALARM_PULSE = s.pulse;
    assign PWR_SWITCH_O = s.pin_o;
    assign PWR_SWITCH_OE = s.pin_oe;
    assign SAMPLE_WINDOW = s.samp_act;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    enable_gate_a:
        assert property ((CE && !s.alcfg[ALCFG_EN_BIT]) |=> !ALARM_IRQ)
        else $error("alarm fired while disabled");
    half_mask_a:
        assert property ((CE && TICK_HALF && s.alcfg[ALCFG_EN_BIT] && s.ctrl[CTRL_CU_EN_BIT]
                          && s.alcfg[ALCFG_MASK_HI:ALCFG_MASK_LO] == MASK_HALF) |=> ALARM_IRQ)
        else $error("half second alarm missed");
    rpt_dec_a:
        assert property ((CE && fire && !wr_cfg && !(BROWNOUT_EN && s.bo_level)
                          && s.alcfg[7:0] != 8'h00)
                         |=> s.alcfg[7:0] == $past(s.alcfg[7:0]) - 8'h01)
        else $error("repeat count not decremented");
    last_off_a:
        assert property ((CE && fire && !wr_cfg && s.alcfg[7:0] == 8'h00
                          && !s.alcfg[ALCFG_ENDLESS_REPEAT_BIT_BIT]) |=> !s.alcfg[ALCFG_EN_BIT])
        else $error("enable not cleared after last alarm");
    endless_repeat_bit_wrap_a:
        assert property ((CE && fire && !wr_cfg && !(BROWNOUT_EN && s.bo_level)
                          && s.alcfg[7:0] == 8'h00 && s.alcfg[ALCFG_ENDLESS_REPEAT_BIT_BIT])
                         |=> s.alcfg[ALCFG_EN_BIT] && s.alcfg[7:0] == 8'hff)
        else $error("endless_repeat_bit did not wrap count");
    pulse_toggle_a:
        assert property ((CE && fire) |=> ALARM_PULSE != $past(ALARM_PULSE))
        else $error("alarm pulse did not toggle");
    pin_gate_a:
        assert property (PWR_SWITCH_OE |-> s.ctrl[0] && s.pwctl[15] && s.ctrl[1]
                         && s.ctrl[3:2] == 2'h3)
        else $error("pin driven without all enables");
    polarity_a:
        assert property (PWR_SWITCH_OE |-> PWR_SWITCH_O == (s.pwctl[14] ~^ s.pwr_on))
        else $error("switch level ignores polarity");
    stab_end_a:
        assert property ((CE && s.fsm == PWC_STAB && PWC_TICK && s.cnt == 8'h01
                          && s.swt[7:0] != 8'h00 && s.pwctl[15] && s.ctrl[0]
                          && !(BROWNOUT_EN && s.bo_level)) |=> SAMPLE_WINDOW && s.pwr_on)
        else $error("sample window did not follow stability");
    samp_all_a:
        assert property ((s.swt[7:0] == 8'hff) |-> SAMPLE_WINDOW)
        else $error("all-ones sample window not active");
    brownout_a:
        assert property ((CE && BROWNOUT_EN && s.bo_level) |=> !CLK_UNIT_EN [*2])
        else $error("brown-out did not disable clock unit");

endmodule

// ===== rtl/rap_pkg.sv
package rap_pkg;

    // ************************************************************
    // register map (word index on the plain register port)
    // ************************************************************
    localparam logic [3:0] ADDR_ALCFG = 4'h0;
    localparam logic [3:0] ADDR_AL_MINSEC = 4'h1;
    localparam logic [3:0] ADDR_AL_WDHR = 4'h2;
    localparam logic [3:0] ADDR_AL_MTHDY = 4'h3;
    localparam logic [3:0] ADDR_PWCTL = 4'h4;
    localparam logic [3:0] ADDR_SWT = 4'h5;
    localparam logic [3:0] ADDR_CTRL = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ALCFG_EN_BIT = 15;
    localparam int ALCFG_ENDLESS_REPEAT_BIT_BIT = 14;
    localparam int ALCFG_MASK_HI = 13;
    localparam int ALCFG_MASK_LO = 10;
    localparam int ALCFG_RPT_HI = 7;
    localparam int PWCTL_EN_BIT = 15;
    localparam int PWCTL_POL_BIT = 14;
    localparam int SWT_STAB_HI = 15;
    localparam int SWT_STAB_LO = 8;
    localparam int SWT_SAMP_HI = 7;
    localparam int CTRL_CU_EN_BIT = 0;
    localparam int CTRL_PIN_OE_BIT = 1;
    localparam int CTRL_PIN_SEL_HI = 3;
    localparam int CTRL_PIN_SEL_LO = 2;
    localparam int STAT_BO_SEEN_BIT = 3;

    // ************************************************************
    // values
    // ************************************************************
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [1:0] PIN_SEL_PWC = 2'h3;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ALL = 8'hff;

    typedef enum logic [3:0] {
        MASK_HALF = 4'h0, MASK_SEC = 4'h1, MASK_TENSEC = 4'h2, MASK_MIN = 4'h3,
        MASK_TENMIN = 4'h4, MASK_HOUR = 4'h5, MASK_DAY = 4'h6, MASK_WEEK = 4'h7,
        MASK_MONTH = 4'h8, MASK_YEAR = 4'h9
    } rap_mask_type;

    typedef enum logic [1:0] {
        PWC_IDLE = 2'h0,
        PWC_STAB = 2'h1,
        PWC_SAMP = 2'h3
    } rap_pwc_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } rap_bus_type;

    // bcd time digits; half is set in the second half of each second
    typedef struct packed {
        logic half;
        logic mon_ten;
        logic [3:0] mon_one;
        logic [1:0] day_ten;
        logic [3:0] day_one;
        logic [2:0] wday;
        logic [1:0] hr_ten;
        logic [3:0] hr_one;
        logic [2:0] min_ten;
        logic [3:0] min_one;
        logic [2:0] sec_ten;
        logic [3:0] sec_one;
    } rap_time_type;

endpackage

// ===== testbench/rap_ext_dev.sv
`timescale 1ns/1ps

// ****************************************
// switched external device
// ****************************************
module rap_ext_dev (
    input wire logic pin_level,
    input wire logic active_high,
    output logic powered
);
    // the switch conducts only on the level that software selected
    assign powered = active_high ? pin_level : !pin_level;
endmodule

// ===== testbench/rap_alarm_pwc_tb.sv
`timescale 1ns/1ps

module rap_alarm_pwc_tb;
    import rap_pkg::*;
    // repeat counts per case, case 0 in the low byte
    localparam logic [39:0] RPT_TAB = 40'h03_ff00_0002;
    localparam logic [4:0] ENDLESS_REPEAT_BIT_TAB = 5'h14;
    logic CORE_CLK, RST, CE, TICK_HALF, PWC_TICK, ROLLOVER_SYNC, BROWNOUT_EN, BROWNOUT_PIN;
    rap_bus_type BUS_REQ;
    rap_time_type CUR_TIME;
    logic [15:0] RD_DATA;
    logic CLK_UNIT_EN, ALARM_IRQ, ALARM_PULSE, PWR_SWITCH_O, PWR_SWITCH_OE, SAMPLE_WINDOW;
    logic pin_level, powered, pol, exp_pulse;
    int n_mismatch, checks_done, cycles;

    rap_alarm_pwc dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .BUS_REQ(BUS_REQ),
        .RD_DATA(RD_DATA), .CUR_TIME(CUR_TIME), .TICK_HALF(TICK_HALF), .PWC_TICK(PWC_TICK),
        .ROLLOVER_SYNC(ROLLOVER_SYNC), .BROWNOUT_EN(BROWNOUT_EN), .BROWNOUT_PIN(BROWNOUT_PIN),
        .CLK_UNIT_EN(CLK_UNIT_EN), .ALARM_IRQ(ALARM_IRQ), .ALARM_PULSE(ALARM_PULSE),
        .PWR_SWITCH_O(PWR_SWITCH_O), .PWR_SWITCH_OE(PWR_SWITCH_OE),
        .SAMPLE_WINDOW(SAMPLE_WINDOW));
    // released pin floats to the external pull-up
    assign pin_level = PWR_SWITCH_OE ? PWR_SWITCH_O : 1'b1;
    rap_ext_dev ext_u (.pin_level(pin_level), .active_high(pol), .powered(powered));

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        BUS_REQ <= {1'b1, 1'b0, a, d};
        @(posedge CORE_CLK);
        BUS_REQ <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge CORE_CLK);
        BUS_REQ <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge CORE_CLK);
        BUS_REQ <= '0;
        #1;
        chk(RD_DATA & m, e);
    endtask

    task automatic tick(input logic exp);
        @(posedge CORE_CLK);
        TICK_HALF <= 1'b1;
        @(posedge CORE_CLK);
        TICK_HALF <= 1'b0;
        #1;
        exp_pulse = exp_pulse ^ exp;
        chk(ALARM_IRQ, exp);
        chk(ALARM_PULSE, exp_pulse);
    endtask

    task automatic ptick(input int n);
        repeat (n) begin
            @(posedge CORE_CLK);
            PWC_TICK <= 1'b1;
            @(posedge CORE_CLK);
            PWC_TICK <= 1'b0;
        end
        #1;
    endtask

    task automatic set_alarm(input rap_time_type a, input logic [15:0] cfg);
        wr(ADDR_ALCFG, 16'h0000);
        wr(ADDR_AL_MINSEC, {1'h0, a.min_ten, a.min_one, 1'h0, a.sec_ten, a.sec_one});
        wr(ADDR_AL_WDHR, {5'h00, a.wday, 2'h0, a.hr_ten, a.hr_one});
        wr(ADDR_AL_MTHDY, {3'h0, a.mon_ten, a.mon_one, 2'h0, a.day_ten, a.day_one});
        wr(ADDR_ALCFG, cfg);
    endtask

    function automatic rap_time_type rnd_time();
        rap_time_type r;
        r = '0;
        r.sec_one = 4'($urandom_range(9));
        r.sec_ten = 3'($urandom_range(5));
        r.min_one = 4'($urandom_range(9));
        r.min_ten = 3'($urandom_range(5));
        r.hr_one = 4'($urandom_range(9));
        r.hr_ten = 2'($urandom_range(1));
        r.wday = 3'($urandom_range(6));
        r.day_one = 4'($urandom_range(9, 1));
        r.day_ten = 2'($urandom_range(2));
        r.mon_one = 4'($urandom_range(9, 1));
        return r;
    endfunction

    function automatic logic hit(input logic [3:0] m, input rap_time_type a,
                                 input rap_time_type t);
        hit = (m <= 4'h9);
        if (m >= 4'h1) hit &= !t.half;
        if (m >= 4'h2) hit &= (t.sec_one == a.sec_one);
        if (m >= 4'h3) hit &= (t.sec_ten == a.sec_ten);
        if (m >= 4'h4) hit &= (t.min_one == a.min_one);
        if (m >= 4'h5) hit &= (t.min_ten == a.min_ten);
        if (m >= 4'h6) hit &= ({t.hr_ten, t.hr_one} == {a.hr_ten, a.hr_one});
        if (m == 4'h7) hit &= (t.wday == a.wday);
        if (m >= 4'h8) hit &= ({t.day_ten, t.day_one} == {a.day_ten, a.day_one});
        if (m >= 4'h9) hit &= ({t.mon_ten, t.mon_one} == {a.mon_ten, a.mon_one});
    endfunction

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rap_time_type a, t;
        logic [3:0] m;
        logic [7:0] cnt;
        logic [7:0] stab;
        logic on, ch;
        RST = 1'b1;
        CE = 1'b1;
        BUS_REQ = '0;
        CUR_TIME = '0;
        TICK_HALF = 1'b0;
        PWC_TICK = 1'b0;
        ROLLOVER_SYNC = 1'b0;
        BROWNOUT_EN = 1'b0;
        BROWNOUT_PIN = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        exp_pulse = 1'b0;
        pol = 1'b0;
        void'($urandom(95367));
        repeat (3) @(posedge CORE_CLK);
        RST <= 1'b0;
        for (int i = 0; i < 8; i++) rd_chk(4'(i), 16'hffff, 16'h0000);
        for (int i = 8; i < 16; i++) begin
            wr(4'(i), 16'hffff);
            rd_chk(4'(i), 16'hffff, 16'h0000);
        end
        wr(ADDR_ALCFG, 16'h7cff);
        rd_chk(ADDR_ALCFG, 16'hfcff, 16'h7cff);
        @(posedge CORE_CLK);
        ROLLOVER_SYNC <= 1'b1;
        rd_chk(ADDR_STATUS, 16'h0001, 16'h0001);
        ROLLOVER_SYNC <= 1'b0;
        $display("test registers done");
        wr(ADDR_CTRL, 16'h0001);
        for (int i = 0; i < 44; i++) begin
            m = 4'(i / 4);
            a = rnd_time();
            set_alarm(a, {2'h3, m, 10'h000});
            t = (i % 4 == 3) ? rnd_time() : a;
            t.half = (i % 4 == 1);
            if (i % 4 == 2) t.min_one = 4'($urandom_range(9));
            if (i % 4 == 2) t.wday = 3'($urandom_range(6));
            @(posedge CORE_CLK);
            CUR_TIME <= t;
            tick(hit(m, a, t));
        end
        // yearly alarm on a leap day must not slip to a nearby date
        a.mon_ten = 1'h0;
        a.mon_one = 4'h2;
        a.day_ten = 2'h2;
        a.day_one = 4'h9;
        set_alarm(a, 16'ha400);
        t = a;
        t.day_one = 4'h8;
        @(posedge CORE_CLK);
        CUR_TIME <= t;
        tick(1'b0);
        @(posedge CORE_CLK);
        CUR_TIME <= a;
        tick(1'b1);
        $display("test masks done");
        for (int k = 0; k < 5; k++) begin
            cnt = RPT_TAB[8 * k +: 8];
            ch = ENDLESS_REPEAT_BIT_TAB[k];
            on = 1'b1;
            set_alarm(a, {1'h1, ch, 6'h00, cnt});
            repeat (4) begin
                tick(on);
                if (on && cnt == 8'h00) begin
                    if (ch) cnt = 8'hff;
                    else on = 1'b0;
                end else if (on) cnt = cnt - 8'h01;
            end
            rd_chk(ADDR_ALCFG, 16'hc0ff, {on, ch, 6'h00, cnt});
        end
        set_alarm(a, 16'h0000);
        tick(1'b0);
        wr(ADDR_CTRL, 16'h0000);
        set_alarm(a, 16'h8000);
        tick(1'b0);
        $display("test repeat done");
        for (int k = 0; k < 4; k++) begin
            pol = k[1];
            stab = k[0] ? 8'h02 : 8'h00;
            wr(ADDR_CTRL, 16'h000f);
            wr(ADDR_PWCTL, {1'h1, pol, 14'h0000});
            wr(ADDR_SWT, {stab, 8'h01});
            set_alarm(a, 16'hc000);
            tick(1'b1);
            @(posedge CORE_CLK);
            #1;
            chk(powered, 1'b1);
            chk(SAMPLE_WINDOW, stab == 8'h00);
            ptick(int'(stab));
            chk(SAMPLE_WINDOW, 1'b1);
            chk(powered, 1'b1);
            ptick(1);
            chk(SAMPLE_WINDOW, 1'b0);
            chk(powered, 1'b0);
        end
        // endless_repeat_bit keeps the alarm armed, so the power cycle comes round again
        tick(1'b1);
        @(posedge CORE_CLK);
        #1;
        chk(powered, 1'b1);
        ptick(3);
        chk(powered, 1'b0);
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_CTRL, {12'h000, 4'(c)});
            repeat (2) @(posedge CORE_CLK);
            #1;
            chk(PWR_SWITCH_OE, c == 15);
            chk(CLK_UNIT_EN, c % 2);
        end
        wr(ADDR_PWCTL, 16'h0000);
        wr(ADDR_SWT, 16'h00ff);
        repeat (2) @(posedge CORE_CLK);
        #1;
        chk(SAMPLE_WINDOW, 1'b1);
        wr(ADDR_SWT, 16'h0000);
        $display("test power done");
        wr(ADDR_CTRL, 16'h0001);
        set_alarm(a, 16'h8000);
        BROWNOUT_EN <= 1'b1;
        BROWNOUT_PIN <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        BROWNOUT_PIN <= 1'b0;
        #1;
        chk(CLK_UNIT_EN, 1'b0);
        rd_chk(ADDR_ALCFG, 16'h8000, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0008, 16'h0008);
        repeat (6) @(posedge CORE_CLK);
        wr(ADDR_STATUS, 16'h0008);
        rd_chk(ADDR_STATUS, 16'h0008, 16'h0000);
        BROWNOUT_EN <= 1'b0;
        wr(ADDR_CTRL, 16'h0001);
        BROWNOUT_PIN <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        BROWNOUT_PIN <= 1'b0;
        #1;
        chk(CLK_UNIT_EN, 1'b1);
        rd_chk(ADDR_STATUS, 16'h0008, 16'h0000);
        $display("test brownout done");
        close_out();
    end
endmodule
